// >>> hw/swc_ms_tick.sv
`timescale 1ns/1ps
module swc_ms_tick import swc_pkg::*; #(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  output logic tick
);

  initial begin
    if (CYCLES < 2) begin
      $error("swc_ms_tick: CYCLES must be at least 2.");
    end
  end

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_cnt = cnt + 32'h1;
    if (cnt == 32'(CYCLES - 1)) begin
      next_cnt = 32'h0;
      next_tick = 1'b1; // [R15]
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule // swc_ms_tick

// >>> hw/swc_pkg.sv
package swc_pkg;

  // ----------------------------------------------------------------------
  // Timebase.
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned TICK_MS_NS = 1000000;
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned TICK_CYCLES = TICK_MS_NS / CLK_NS;

  // ----------------------------------------------------------------------
  // Timing in milliseconds.
  // ----------------------------------------------------------------------
  localparam int unsigned CALL_PULSE_MS = 30;
  localparam int unsigned CALL_PERIOD_S = 5;
  localparam int unsigned CALL_PERIOD_MS = CALL_PERIOD_S * 1000;
  localparam int unsigned SMS_PULSE_MS = 35;
  localparam int unsigned RESLEEP_MIN = 2;
  localparam int unsigned RESLEEP_MS = RESLEEP_MIN * 60 * 1000;
  localparam int unsigned MS_W = 18;

  // ----------------------------------------------------------------------
  // Lamp blink styles and their half periods in milliseconds.
  // ----------------------------------------------------------------------
  localparam logic [1:0] LAMP_OFF = 2'h0;
  localparam logic [1:0] LAMP_SLOW = 2'h1;
  localparam logic [1:0] LAMP_FAST = 2'h2;
  localparam logic [1:0] LAMP_ON = 2'h3;
  localparam int unsigned LAMP_SLOW_MS = 1000;
  localparam int unsigned LAMP_FAST_MS = 125;

  typedef enum logic [1:0] {
    SWC_AWAKE = 2'b00,
    SWC_ASLEEP = 2'b01,
    SWC_EVENT = 2'b11
  } swc_state_e;

  typedef struct packed {
    logic call_ring;
    logic call_answered;
    logic sms_rx;
    logic data_rx;
  } swc_event_s;

endpackage

// >>> hw/swc_ring_pulser.sv
`timescale 1ns/1ps
module swc_ring_pulser import swc_pkg::*; #(
  parameter int unsigned CALL_MS = CALL_PULSE_MS,
  parameter int unsigned PERIOD_MS = CALL_PERIOD_MS,
  parameter int unsigned SMS_MS = SMS_PULSE_MS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic call_active,
  input wire logic sms_pulse,
  output logic ring_n
);

  initial begin
    if (CALL_MS >= PERIOD_MS || PERIOD_MS >= (1 << MS_W) || SMS_MS == 0) begin
      $error("swc_ring_pulser: pulse widths do not fit the period.");
    end
  end

  logic [MS_W-1:0] call_ms;
  logic [MS_W-1:0] next_call_ms;
  logic [MS_W-1:0] sms_ms;
  logic [MS_W-1:0] next_sms_ms;
  logic next_ring_n;

  always_comb begin
    next_call_ms = call_ms;
    next_sms_ms = sms_ms;
    if (!call_active) begin
      next_call_ms = '0; // [R12]
    end else if (tick) begin
      if (call_ms == MS_W'(PERIOD_MS - 1)) begin
        next_call_ms = '0; // [R10]
      end else begin
        next_call_ms = call_ms + MS_W'(1);
      end
    end
    if (sms_pulse) begin
      next_sms_ms = MS_W'(SMS_MS); // [R13]
    end else if (tick && sms_ms != '0) begin
      next_sms_ms = sms_ms - MS_W'(1);
    end
    next_ring_n = !((call_active && call_ms < MS_W'(CALL_MS)) ||
                    next_sms_ms != '0); // [R10] [R13]
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      call_ms <= '0;
      sms_ms <= '0;
      ring_n <= 1'b1;
    end else begin
      call_ms <= next_call_ms;
      sms_ms <= next_sms_ms;
      ring_n <= next_ring_n;
    end
  end

endmodule // swc_ring_pulser

// >>> hw/swc_sleep_ctrl.sv
// Summary of operation
// [R1] Sleep is possible only after the power-save command enables it.
// [R2] Host keeps sleep-control high whenever it does not want sleep.
// [R3] Enabled and sleep-control low puts the module to sleep when idle.
// [R4] Sleep entry waits until processing and pending transfers are done.
// [R5] Sleep-control high wakes the module so it can send and call.
// [R6] Call, data or SMS wakes the module and raises a notification.
// [R7] Host raises sleep-control before handling a wake event.
// [R8] With sleep-control still low, sleep resumes two minutes after service.
// [R9] Host lowers sleep-control after a transaction to resume sleep.
// [R10] Incoming call pulses ring low 30 ms every 5 seconds.
// [R11] Incoming call also requests ring strings on the UART.
// [R12] Answered call stops pulsing and holds ring high.
// [R13] Received SMS gives one 35 ms low ring pulse.
// [R14] Lamp blinks in a selectable style showing module state.
// [R15] All timing comes from a reset-cleared millisecond tick.
// [R16] Sleep-control is an active-low level request, may float high.
`timescale 1ns/1ps
module swc_sleep_ctrl import swc_pkg::*; #(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned RESLEEP_TIMEOUT_MS = RESLEEP_MS,
  parameter int unsigned SLOW_MS = LAMP_SLOW_MS,
  parameter int unsigned FAST_MS = LAMP_FAST_MS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sleep_req_n,
  input wire logic power_save_cmd,
  input wire logic power_save_value,
  input wire logic busy,
  input wire swc_event_s event_in,
  input wire logic [1:0] lamp_style_sleep,
  input wire logic [1:0] lamp_style_awake,
  input wire logic [1:0] lamp_style_event,
  output logic asleep,
  output logic notify_pulse,
  output logic ring_text_req,
  output logic ring_n,
  output logic network_lamp_output
);

  initial begin
    if (RESLEEP_TIMEOUT_MS == 0 || RESLEEP_TIMEOUT_MS >= (1 << MS_W) ||
        SLOW_MS == 0 || FAST_MS == 0 || SLOW_MS >= (1 << MS_W)) begin
      $error("swc_sleep_ctrl: timing parameter out of range.");
    end
  end

  // ----------------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------------
  logic req_meta;
  logic req_sync;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      req_meta <= 1'b1;
      req_sync <= 1'b1;
    end else begin
      req_meta <= sleep_req_n; // [R16]
      req_sync <= req_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond timebase.
  // ----------------------------------------------------------------------
  logic tick;

  swc_ms_tick #(
    .CYCLES(TICK_CYC)
  ) u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // Call tracking and power-save enable.
  // ----------------------------------------------------------------------
  logic save_en;
  logic next_save_en;
  logic call_active;
  logic next_call_active;
  logic any_event;

  always_comb begin
    next_save_en = save_en;
    if (power_save_cmd) begin
      next_save_en = power_save_value; // [R1]
    end
    next_call_active = call_active;
    if (event_in.call_answered) begin
      next_call_active = 1'b0; // [R12]
    end else if (event_in.call_ring) begin
      next_call_active = 1'b1;
    end
    any_event = event_in.call_ring || event_in.sms_rx || event_in.data_rx;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      save_en <= 1'b0;
      call_active <= 1'b0;
    end else begin
      save_en <= next_save_en;
      call_active <= next_call_active;
    end
  end

  // ----------------------------------------------------------------------
  // Sleep state machine.
  // ----------------------------------------------------------------------
  swc_state_e state;
  swc_state_e next_state;
  logic [MS_W-1:0] resleep_ms;
  logic [MS_W-1:0] next_resleep_ms;
  logic next_asleep;
  logic next_notify;
  logic idle;

  always_comb begin
    next_state = state;
    next_resleep_ms = resleep_ms;
    next_notify = 1'b0;
    idle = !busy && !call_active && !any_event; // [R4]
    case (state)
      SWC_AWAKE: begin
        if (save_en && !req_sync && idle) begin
          next_state = SWC_ASLEEP; // [R3]
        end
      end
      SWC_ASLEEP: begin
        if (!save_en || req_sync) begin
          next_state = SWC_AWAKE; // [R1] [R5]
        end else if (any_event) begin
          next_state = SWC_EVENT; // [R6]
          next_notify = 1'b1; // [R6]
          next_resleep_ms = '0;
        end
      end
      SWC_EVENT: begin
        if (!save_en || req_sync) begin
          next_state = SWC_AWAKE; // [R7]
        end else if (!idle) begin
          next_resleep_ms = '0; // [R8]
        end else if (tick) begin
          if (resleep_ms == MS_W'(RESLEEP_TIMEOUT_MS - 1)) begin
            next_state = SWC_ASLEEP; // [R8]
            next_resleep_ms = '0;
          end else begin
            next_resleep_ms = resleep_ms + MS_W'(1);
          end
        end
      end
      default: begin
        next_state = SWC_AWAKE;
        next_resleep_ms = '0;
      end
    endcase
    next_asleep = (next_state == SWC_ASLEEP);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= SWC_AWAKE;
      resleep_ms <= '0;
      asleep <= 1'b0;
      notify_pulse <= 1'b0;
      ring_text_req <= 1'b0;
    end else begin
      state <= next_state;
      resleep_ms <= next_resleep_ms;
      asleep <= next_asleep;
      notify_pulse <= next_notify;
      ring_text_req <= next_call_active; // [R11]
    end
  end

  // ----------------------------------------------------------------------
  // Ring pin.
  // ----------------------------------------------------------------------
  swc_ring_pulser u_ring (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(tick),
    .call_active(next_call_active), // [R12]
    .sms_pulse(event_in.sms_rx),
    .ring_n(ring_n)
  );

  // ----------------------------------------------------------------------
  // Network lamp.
  // ----------------------------------------------------------------------
  logic [1:0] style;
  logic [MS_W-1:0] lamp_ms;
  logic [MS_W-1:0] next_lamp_ms;
  logic [MS_W-1:0] half_ms;
  logic lamp_phase;
  logic next_lamp_phase;
  logic next_lamp;

  function automatic logic [MS_W-1:0] half_of(input logic [1:0] s);
    half_of = (s == LAMP_FAST) ? MS_W'(FAST_MS) : MS_W'(SLOW_MS);
  endfunction

  always_comb begin
    case (state)
      SWC_ASLEEP: style = lamp_style_sleep; // [R14]
      SWC_EVENT: style = lamp_style_event;
      default: style = lamp_style_awake;
    endcase
    half_ms = half_of(style);
    next_lamp_ms = lamp_ms;
    next_lamp_phase = lamp_phase;
    if (tick) begin
      if (lamp_ms >= half_ms - MS_W'(1)) begin
        next_lamp_ms = '0;
        next_lamp_phase = !lamp_phase;
      end else begin
        next_lamp_ms = lamp_ms + MS_W'(1);
      end
    end
    case (style)
      LAMP_OFF: next_lamp = 1'b0;
      LAMP_ON: next_lamp = 1'b1;
      default: next_lamp = next_lamp_phase; // [R14]
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lamp_ms <= '0;
      lamp_phase <= 1'b0;
      network_lamp_output <= 1'b0;
    end else begin
      lamp_ms <= next_lamp_ms;
      lamp_phase <= next_lamp_phase;
      network_lamp_output <= next_lamp;
    end
  end

endmodule // swc_sleep_ctrl

// >>> verif/swc_host_model.sv
`timescale 1ns/1ps
module swc_host_model import swc_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic notify_pulse,
  input wire logic want_sleep,
  input wire logic follow,
  output logic sleep_req_n
);
  // ----------------------------------------------------------------------
  // Host drive of the sleep-control pin.
  // ----------------------------------------------------------------------
  logic hold;
  logic next_hold;
  always_comb begin
    next_hold = want_sleep & (hold | (notify_pulse & follow));
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) hold <= 1'h0;
    else hold <= next_hold;
  end
  assign sleep_req_n = ~want_sleep | hold;
endmodule // swc_host_model

// >>> verif/swc_sleep_ctrl_sva.sv
`timescale 1ns/1ps
module swc_sleep_ctrl_sva import swc_pkg::*; #(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sleep_req_n,
  input wire logic power_save_cmd,
  input wire logic power_save_value,
  input wire logic busy,
  input wire swc_event_s event_in,
  input wire logic asleep,
  input wire logic notify_pulse,
  input wire logic ring_text_req,
  input wire logic ring_n
);
  // ----------------------------------------------------------------------
  // Helper state and properties.
  // ----------------------------------------------------------------------
  logic en;
  logic next_en;
  int unsigned low_cnt;
  int unsigned next_low_cnt;
  always_comb begin
    next_en = power_save_cmd ? power_save_value : en;
    next_low_cnt = ring_n ? 32'h0 : low_cnt + 32'h1;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en <= 1'h0;
      low_cnt <= 32'h0;
    end else begin
      en <= next_en;
      low_cnt <= next_low_cnt;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence pin_wake;
    asleep && $rose(sleep_req_n);
  endsequence
  sequence ring_drop;
    $fell(ring_n);
  endsequence
  notify_one_a: assert property (notify_pulse |=> !notify_pulse)
    else $error("notify longer than one cycle");
  notify_wake_a: assert property (notify_pulse |->
    !asleep && ($past(asleep) || $past(asleep, 2)))
    else $error("notify without a wake from sleep");
  sleep_gate_a: assert property ($rose(asleep) |->
    $past(en) && !$past(sleep_req_n, 3))
    else $error("sleep entered without cause");
  idle_entry_a: assert property ($rose(asleep) |->
    !$past(busy) && !ring_text_req) else $error("sleep entered while busy");
  pin_wake_a: assert property (pin_wake |-> ##[1:6] !asleep)
    else $error("pin high did not wake");
  answer_stop_a: assert property (event_in.call_answered |=>
    ring_n && !ring_text_req) else $error("ring not stopped on answer");
  ring_len_a: assert property (low_cnt <= 36 * TICK_CYC)
    else $error("ring low too long");
  ring_cause_a: assert property (ring_drop |-> ring_text_req ||
    $past(event_in.sms_rx) || $past(event_in.sms_rx, 2) ||
    $past(event_in.call_ring)) else $error("ring pulse without cause");
  text_awake_a: assert property (ring_text_req |-> !asleep)
    else $error("ring text while asleep");
  resleep_hold_a: assert property (notify_pulse |=> (!asleep) [*8])
    else $error("sleep resumed too early");
endmodule // swc_sleep_ctrl_sva

bind swc_sleep_ctrl swc_sleep_ctrl_sva #(.TICK_CYC(TICK_CYC)) u_sva (
  .sys_clk(sys_clk), .reset(reset), .sleep_req_n(sleep_req_n),
  .power_save_cmd(power_save_cmd), .power_save_value(power_save_value),
  .busy(busy), .event_in(event_in), .asleep(asleep),
  .notify_pulse(notify_pulse), .ring_text_req(ring_text_req),
  .ring_n(ring_n));

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb import swc_pkg::*; ;
  localparam int TC = 4;
  localparam int RS = 5;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic want = 1'h0, follow = 1'h0, cmd = 1'h0, val = 1'h0, busy = 1'h0;
  logic [1:0] sty = 2'h0;
  swc_event_s ev = '0;
  logic req_n, asleep, notify, ring_text, ring_n, lamp;
  int fail_count = 0, checks_done = 0, notes = 0;
  // ----------------------------------------------------------------------
  // Clock, instances and shared tasks.
  // ----------------------------------------------------------------------
  always #2 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (notify === 1'h1) notes++;
  swc_host_model u_host (.sys_clk(sys_clk), .reset(reset),
    .notify_pulse(notify), .want_sleep(want), .follow(follow),
    .sleep_req_n(req_n));
  swc_sleep_ctrl #(.TICK_CYC(TC), .RESLEEP_TIMEOUT_MS(RS), .SLOW_MS(4),
    .FAST_MS(2)) dut (.sys_clk(sys_clk), .reset(reset), .sleep_req_n(req_n),
    .power_save_cmd(cmd), .power_save_value(val), .busy(busy),
    .event_in(ev), .lamp_style_sleep(sty), .lamp_style_awake(sty),
    .lamp_style_event(sty), .asleep(asleep), .notify_pulse(notify),
    .ring_text_req(ring_text), .ring_n(ring_n), .network_lamp_output(lamp));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_on(input bit sel, input logic v, output int n);
    n = 0;
    while ((sel ? ring_n : asleep) !== v && n < 30000) begin
      @(negedge sys_clk);
      n++;
    end
    check(n < 30000, 1'h1);
  endtask
  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_lamp();
    int t;
    int e[4];
    logic prev;
    e = '{0, 4, 8, 0};
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      sty <= 2'(s);
      repeat (6) @(negedge sys_clk);
      t = 0;
      prev = lamp;
      repeat (64) begin
        @(negedge sys_clk);
        if (lamp !== prev) t++;
        prev = lamp;
      end
      check(t >= e[s] - 1 && t <= e[s] + 1, 1'h1);
      if (s == 0 || s == 3) check(lamp, s == 3);
    end
  endtask
  task automatic t_disabled();
    @(posedge sys_clk);
    want <= 1'h1;
    repeat (20) @(negedge sys_clk);
    check(asleep, 1'h0);
  endtask
  task automatic t_busy();
    int n;
    @(posedge sys_clk);
    cmd <= 1'h1;
    val <= 1'h1;
    busy <= 1'h1;
    @(posedge sys_clk);
    cmd <= 1'h0;
    repeat (20) @(negedge sys_clk);
    check(asleep, 1'h0);
    @(posedge sys_clk);
    busy <= 1'h0;
    wait_on(0, 1'h1, n);
    check(n < 8, 1'h1);
  endtask
  task automatic t_pin_wake();
    int n;
    @(posedge sys_clk);
    want <= 1'h0;
    wait_on(0, 1'h0, n);
    check(n < 8, 1'h1);
    @(posedge sys_clk);
    want <= 1'h1;
    wait_on(0, 1'h1, n);
    check(n < 8, 1'h1);
  endtask
  task automatic t_sms();
    int a, w, b;
    @(posedge sys_clk);
    ev.sms_rx <= 1'h1;
    @(posedge sys_clk);
    ev.sms_rx <= 1'h0;
    wait_on(0, 1'h0, a);
    wait_on(1, 1'h0, a);
    wait_on(1, 1'h1, w);
    check(notes, 1);
    check(w >= 34 * TC && w <= 36 * TC, 1'h1);
    wait_on(0, 1'h1, b);
    check(a + w + b >= (RS - 1) * TC, 1'h1);
  endtask
  task automatic t_call();
    int a, w, g;
    @(posedge sys_clk);
    follow <= 1'h1;
    ev.call_ring <= 1'h1;
    @(posedge sys_clk);
    ev.call_ring <= 1'h0;
    wait_on(0, 1'h0, a);
    @(negedge sys_clk);
    check(notes, 2);
    check(ring_text, 1'h1);
    wait_on(1, 1'h0, a);
    wait_on(1, 1'h1, w);
    check(w >= 29 * TC && w <= 31 * TC, 1'h1);
    wait_on(1, 1'h0, g);
    check(w + g >= 4999 * TC && w + g <= 5001 * TC, 1'h1);
    check(asleep, 1'h0);
    @(posedge sys_clk);
    ev.call_answered <= 1'h1;
    @(posedge sys_clk);
    ev.call_answered <= 1'h0;
    repeat (2) @(negedge sys_clk);
    check({ring_n, ring_text}, 2'h2);
    repeat (200) @(negedge sys_clk);
    check(ring_n, 1'h1);
    @(posedge sys_clk);
    want <= 1'h0;
    @(posedge sys_clk);
    want <= 1'h1;
    wait_on(0, 1'h1, a);
    check(a < 8, 1'h1);
  endtask
  task automatic t_data();
    int n;
    @(posedge sys_clk);
    ev.data_rx <= 1'h1;
    @(posedge sys_clk);
    ev.data_rx <= 1'h0;
    wait_on(0, 1'h0, n);
    check(n < 8, 1'h1);
    @(negedge sys_clk);
    check(notes, 3);
  endtask
  initial begin
    #400000;
    fail_count++;
    results();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'h0;
    t_lamp();
    t_disabled();
    t_busy();
    t_pin_wake();
    t_sms();
    t_call();
    t_data();
    results();
  end
endmodule // tb
